/* File: hdl/pwsfs_params.svh */
// constants of the power switch fault sequencer
`ifndef PWSFS_PARAMS_SVH
`define PWSFS_PARAMS_SVH
`define PWSFS_CLK_MHZ 200
// timing figures in their own units
`define PWSFS_ALERT_CUTOFF_MS 500
`define PWSFS_TURN_ON_MS 20
`define PWSFS_REL_DEB_MS 50
`define PWSFS_DIE_REC_MS 30
`define PWSFS_OV_REC_MS 30
`define PWSFS_SHORT_RETRY_MS 30
`define PWSFS_SENSE_PERIOD_MS 2500
`define PWSFS_BIAS_ON_US 5000
`define PWSFS_BIAS_SETTLE_US 1600
`define PWSFS_OV_RESP_NS 100
`define PWSFS_SHORT_RESP_NS 5000
// derived cycle counts at the clock rate
`define PWSFS_MS_CYC(ms) ((ms) * 1000 * `PWSFS_CLK_MHZ)
`define PWSFS_US_CYC(us) ((us) * `PWSFS_CLK_MHZ)
`define PWSFS_OV_RESP_CYC ((`PWSFS_OV_RESP_NS * `PWSFS_CLK_MHZ) / 1000)
`define PWSFS_SHORT_RESP_CYC ((`PWSFS_SHORT_RESP_NS * `PWSFS_CLK_MHZ) / 1000)
// register map
`define PWSFS_ADDR_CTRL 8'h00
`define PWSFS_ADDR_STATUS 8'h04
`define PWSFS_ADDR_IRQ_STAT 8'h08
`define PWSFS_ADDR_IRQ_MASK 8'h0C
`define PWSFS_ADDR_ID 8'h10
`define PWSFS_ID_VALUE 32'h0000_5A01
`define PWSFS_CTRL_RESET 32'h0000_0001
`define PWSFS_MASK_RESET 32'h0000_0000
// event bit positions
`define PWSFS_EV_OT 0
`define PWSFS_EV_CUTOFF 1
`define PWSFS_EV_DIE 2
`define PWSFS_EV_OV 3
`define PWSFS_EV_SHORT 4
`define PWSFS_EV_SOFT 5
`define PWSFS_EV_W 6
`endif

/* File: hdl/pwsfs_pkg.sv */
// types of the power switch fault sequencer
`default_nettype none
package pwsfs_pkg;
  typedef enum logic [2:0] {
    PWSFS_OFF = 3'b000,
    PWSFS_WAIT_ON = 3'b001,
    PWSFS_ON = 3'b011,
    PWSFS_FAULT = 3'b010,
    PWSFS_RECOVER = 3'b110
  } pwsfs_sw_e;
  typedef struct packed {
    logic over_temp_a;
    logic over_temp_b;
    logic die_hot;
    logic ov_ext;
    logic ov_int;
    logic ov_pin_grounded;
    logic out_low;
    logic adapter_valid;
    logic on_battery;
  } pwsfs_sense_s;
  typedef struct packed {
    logic sw_enable;
    logic discharge_en;
    logic soft_start;
  } pwsfs_drive_s;
endpackage : pwsfs_pkg
`default_nettype wire

/* File: hdl/pwsfs_delay.sv */
// loadable down counter that flags expiry of a delay
`default_nettype none
module pwsfs_delay #(
  parameter int W = 32
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic start, // load count and run
  input wire logic stop, // abandon the count
  input wire logic [W-1:0] count, // cycles to wait
  output logic running, // delay in progress
  output logic done // one-cycle expiry pulse
);
  logic [W-1:0] cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (stop) begin
        running <= 1'b0;
      end else if (start) begin
        cnt_reg <= count;
        running <= 1'b1;
      end else if (running) begin
        if (cnt_reg <= W'(1)) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - W'(1);
        end
      end
    end
  end
endmodule : pwsfs_delay
`default_nettype wire

/* File: hdl/pwsfs_top.sv */
// fault sequencer of a load power switch with an axi4-lite status port
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`include "pwsfs_params.svh"
`default_nettype none
// Contract
// RULE1: any thermistor over-temperature drives the alert line high
// RULE2: after cutoff delay with over-temperature still present, open switch, pull disconnect low
// RULE3: when temperature fault clears, close switch and release disconnect promptly
// RULE4: die overheat opens switch immediately, discharge stays disabled
// RULE5: after die overheat clears, wait recovery delay before re-enabling switch
// RULE6: grounded overvoltage pin selects internal threshold, else external divider compare
// RULE7: overvoltage opens the switch in under 100 ns
// RULE8: after overvoltage clears, wait recovery delay before closing switch
// RULE9: discharge resistors stay disabled throughout an overvoltage event
// RULE10: on battery, pulse bias rail on 5 ms every 2.5 s
// RULE11: sample thermistor comparators only after 1.6 ms settle in each window
// RULE12: on adapter power, bias rail is not duty-cycled
// RULE13: output below 2.35 V after close opens switch within 5 us
// RULE14: after short trip retry at 30 ms, soft-start if short persists
// RULE15: alert-to-cutoff delay is typically 500 ms
// RULE16: after adapter valid wait 20 ms, masking ov, ot and brownout; the switch alone ignores ov and ot, alert still follows ot, no brownout input
// RULE17: thermal fault release is debounced for 50 ms
// RULE18: alert returns low when over-temperature clears; delays from clock counters
module pwsfs_top #(
  parameter int ALERT_CYC = `PWSFS_MS_CYC(`PWSFS_ALERT_CUTOFF_MS),
  parameter int TURN_ON_CYC = `PWSFS_MS_CYC(`PWSFS_TURN_ON_MS),
  parameter int REL_DEB_CYC = `PWSFS_MS_CYC(`PWSFS_REL_DEB_MS),
  parameter int DIE_REC_CYC = `PWSFS_MS_CYC(`PWSFS_DIE_REC_MS),
  parameter int OV_REC_CYC = `PWSFS_MS_CYC(`PWSFS_OV_REC_MS),
  parameter int RETRY_CYC = `PWSFS_MS_CYC(`PWSFS_SHORT_RETRY_MS),
  parameter int PERIOD_CYC = `PWSFS_MS_CYC(`PWSFS_SENSE_PERIOD_MS),
  parameter int BIAS_ON_CYC = `PWSFS_US_CYC(`PWSFS_BIAS_ON_US),
  parameter int SETTLE_CYC = `PWSFS_US_CYC(`PWSFS_BIAS_SETTLE_US)
) (
  input wire logic aclk, // clock, 200 MHz
  input wire logic aresetn, // sync reset, active low
  input wire pwsfs_pkg::pwsfs_sense_s sense_in, // comparator outputs, asynchronous
  output pwsfs_pkg::pwsfs_drive_s drive_out, // switch, discharge, soft start
  output logic alert_o, // alert line level
  output logic alert_oe, // alert line drive enable
  output logic pack_disconnect_n_o, // disconnect pin level, always 0
  output logic pack_disconnect_n_oe, // high while pulling disconnect low
  output logic sensor_bias_rail, // thermistor bias rail enable
  output logic irq, // level interrupt
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  import pwsfs_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  pwsfs_sense_s sync1_reg, sense;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sense <= '0;
    end else begin
      sync1_reg <= sense_in;
      sense <= sync1_reg;
    end
  end

  // ----------------------------------------
  // thermistor bias duty cycle
  // ----------------------------------------
  logic [31:0] period_reg;
  logic sample_en;
  always_ff @(posedge aclk) begin
    if (!aresetn || !sense.on_battery) begin
      period_reg <= '0;
    end else if (period_reg >= 32'(PERIOD_CYC - 1)) begin
      period_reg <= '0; // RULE10
    end else begin
      period_reg <= period_reg + 32'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sensor_bias_rail <= 1'b1;
      sample_en <= 1'b0;
    end else if (!sense.on_battery) begin
      sensor_bias_rail <= 1'b1; // RULE12
      sample_en <= 1'b1;
    end else begin
      sensor_bias_rail <= (period_reg < 32'(BIAS_ON_CYC)); // RULE10
      sample_en <= (period_reg >= 32'(SETTLE_CYC)) && (period_reg < 32'(BIAS_ON_CYC)); // RULE11
    end
  end

  // ----------------------------------------
  // over-temperature qualification
  // ----------------------------------------
  logic ot_sample_reg, ot_fault_reg;
  logic [31:0] rel_cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ot_sample_reg <= 1'b0;
    end else if (sample_en) begin
      ot_sample_reg <= sense.over_temp_a | sense.over_temp_b; // RULE1 RULE11
    end
  end
  // release must hold for the debounce time; a new trip restarts it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ot_fault_reg <= 1'b0;
      rel_cnt_reg <= '0;
    end else if (ot_sample_reg) begin
      ot_fault_reg <= 1'b1;
      rel_cnt_reg <= '0;
    end else if (ot_fault_reg) begin
      if (rel_cnt_reg >= 32'(REL_DEB_CYC - 1)) begin
        ot_fault_reg <= 1'b0; // RULE17
        rel_cnt_reg <= '0;
      end else begin
        rel_cnt_reg <= rel_cnt_reg + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // overvoltage source and fault timers
  // ----------------------------------------
  logic ov_now, ov_seen_reg, die_seen_reg, short_trip;
  logic cut_run, cut_done, start_run, start_done, rec_run, rec_done;
  logic cutoff_reg, retry_pend_reg;
  logic [31:0] rec_count;
  pwsfs_sw_e sw_reg;
  assign ov_now = sense.ov_pin_grounded ? sense.ov_int : sense.ov_ext; // RULE6
  assign short_trip = (sw_reg == PWSFS_ON) && sense.out_low; // RULE13

  // alert-to-cutoff delay, restarted on each new alert
  pwsfs_delay u_cut (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(ot_fault_reg && !alert_o),
    .stop(!ot_fault_reg),
    .count(32'(ALERT_CYC)),
    .running(cut_run),
    .done(cut_done)
  );
  // turn-on delay after adapter valid
  pwsfs_delay u_start (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(sw_reg == PWSFS_OFF && sense.adapter_valid),
    .stop(!sense.adapter_valid),
    .count(32'(TURN_ON_CYC)),
    .running(start_run),
    .done(start_done)
  );
  // one recovery timer serves die, overvoltage and short retry
  assign rec_count = retry_pend_reg ? 32'(RETRY_CYC) :
                     die_seen_reg ? 32'(DIE_REC_CYC) : 32'(OV_REC_CYC);
  pwsfs_delay u_rec (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(sw_reg == PWSFS_FAULT && !sense.die_hot && !ov_now &&
           (retry_pend_reg || !ot_fault_reg || !cutoff_reg)),
    .stop(sw_reg != PWSFS_FAULT && sw_reg != PWSFS_RECOVER),
    .count(rec_count),
    .running(rec_run),
    .done(rec_done)
  );

  // ----------------------------------------
  // alert line and pack disconnect
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_o <= 1'b0;
      cutoff_reg <= 1'b0;
    end else begin
      alert_o <= ot_fault_reg; // RULE1 RULE18
      if (!ot_fault_reg) begin
        cutoff_reg <= 1'b0; // RULE3
      end else if (cut_done) begin
        cutoff_reg <= 1'b1; // RULE2 RULE15
      end
    end
  end
  assign alert_oe = 1'b1;
  assign pack_disconnect_n_o = 1'b0;
  assign pack_disconnect_n_oe = cutoff_reg; // RULE2 RULE3

  // ----------------------------------------
  // switch state machine
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_reg <= PWSFS_OFF;
      die_seen_reg <= 1'b0;
      ov_seen_reg <= 1'b0;
      retry_pend_reg <= 1'b0;
      drive_out <= '0;
    end else begin
      case (sw_reg)
        PWSFS_OFF: begin
          drive_out <= '{sw_enable: 1'b0, discharge_en: 1'b1, soft_start: 1'b0};
          if (sense.adapter_valid) sw_reg <= PWSFS_WAIT_ON;
        end
        PWSFS_WAIT_ON: begin
          // faults masked while the turn-on delay runs
          drive_out.discharge_en <= 1'b0; // RULE16
          if (!sense.adapter_valid) begin
            sw_reg <= PWSFS_OFF;
          end else if (start_done) begin
            sw_reg <= PWSFS_ON; // RULE16
            drive_out.sw_enable <= 1'b1;
            drive_out.soft_start <= 1'b1;
          end
        end
        PWSFS_ON: begin
          drive_out.discharge_en <= 1'b0;
          drive_out.soft_start <= 1'b0;
          if (sense.die_hot || ov_now || short_trip || cutoff_reg) begin
            sw_reg <= PWSFS_FAULT;
            drive_out.sw_enable <= 1'b0; // RULE4 RULE7 RULE13 RULE2
            die_seen_reg <= sense.die_hot;
            ov_seen_reg <= ov_now;
            retry_pend_reg <= short_trip && !sense.die_hot && !ov_now;
          end else if (!sense.adapter_valid) begin
            sw_reg <= PWSFS_OFF;
            drive_out.sw_enable <= 1'b0;
          end
        end
        PWSFS_FAULT: begin
          drive_out.sw_enable <= 1'b0;
          // no discharge for die heat, overvoltage or short
          drive_out.discharge_en <= cutoff_reg && !sense.die_hot && !ov_now && !retry_pend_reg; // RULE4 RULE9
          if (sense.die_hot) die_seen_reg <= 1'b1;
          if (ov_now) ov_seen_reg <= 1'b1;
          if (!sense.adapter_valid) sw_reg <= PWSFS_OFF;
          else if (!cutoff_reg && !ov_seen_reg && !die_seen_reg && !retry_pend_reg) begin
            sw_reg <= PWSFS_ON; // RULE3
            drive_out.sw_enable <= 1'b1;
          end else if (rec_run) sw_reg <= PWSFS_RECOVER;
        end
        PWSFS_RECOVER: begin
          drive_out.discharge_en <= 1'b0;
          if (sense.die_hot || ov_now || !sense.adapter_valid) begin
            sw_reg <= PWSFS_FAULT;
          end else if (rec_done) begin
            sw_reg <= PWSFS_ON; // RULE5 RULE8 RULE14
            drive_out.sw_enable <= 1'b1;
            drive_out.soft_start <= retry_pend_reg; // RULE14
            die_seen_reg <= 1'b0;
            ov_seen_reg <= 1'b0;
            retry_pend_reg <= 1'b0;
          end
        end
        default: sw_reg <= PWSFS_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  logic [`PWSFS_EV_W-1:0] ev, stat_reg, mask_reg;
  logic ctrl_irq_en_reg, rd_stat;
  always_comb begin
    ev = '0;
    ev[`PWSFS_EV_OT] = ot_fault_reg && !alert_o;
    ev[`PWSFS_EV_CUTOFF] = cut_done;
    ev[`PWSFS_EV_DIE] = sw_reg == PWSFS_ON && sense.die_hot;
    ev[`PWSFS_EV_OV] = sw_reg == PWSFS_ON && ov_now;
    ev[`PWSFS_EV_SHORT] = short_trip;
    ev[`PWSFS_EV_SOFT] = rec_done && retry_pend_reg;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (rd_stat ? '0 : stat_reg) | ev; // set wins over read clear
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= ctrl_irq_en_reg && |(stat_reg & mask_reg);
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic aw_hold, w_hold;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  assign aw_hold = !s_axi_awready;
  assign w_hold = !s_axi_wready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      ctrl_irq_en_reg <= 1'(`PWSFS_CTRL_RESET);
      mask_reg <= `PWSFS_EV_W'(`PWSFS_MASK_RESET);
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (aw_hold && w_hold && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (awaddr_reg)
          `PWSFS_ADDR_CTRL: ctrl_irq_en_reg <= wdata_reg[0];
          `PWSFS_ADDR_IRQ_MASK: mask_reg <= wdata_reg[`PWSFS_EV_W-1:0];
          `PWSFS_ADDR_STATUS, `PWSFS_ADDR_IRQ_STAT, `PWSFS_ADDR_ID: ;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  assign rd_stat = s_axi_arvalid && s_axi_arready && s_axi_araddr == `PWSFS_ADDR_IRQ_STAT;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `PWSFS_ADDR_CTRL: s_axi_rdata <= {31'h0, ctrl_irq_en_reg};
        `PWSFS_ADDR_STATUS: s_axi_rdata <= {24'h0, alert_o, cutoff_reg,
                                            drive_out.sw_enable, 2'h0, sw_reg};
        `PWSFS_ADDR_IRQ_STAT: s_axi_rdata <= {26'h0, stat_reg};
        `PWSFS_ADDR_IRQ_MASK: s_axi_rdata <= {26'h0, mask_reg};
        `PWSFS_ADDR_ID: s_axi_rdata <= `PWSFS_ID_VALUE; // arbitrary value
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : pwsfs_top
`default_nettype wire

/* File: verification/pwsfs_host_model.sv */
// host and pack side model: resolves the alert and disconnect wires
`default_nettype none
module pwsfs_host_model (
  input wire logic alert_o, // alert level
  input wire logic alert_oe, // alert enable
  input wire logic disc_o, // disconnect level
  input wire logic disc_oe, // disconnect pull enable
  output logic alert_w, // alert wire
  output logic disc_w // disconnect wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // weak pull-down on alert, external pull-up on disconnect
  assign alert_w = alert_oe ? alert_o : 1'b0;
  assign disc_w = disc_oe ? disc_o : 1'b1;
endmodule : pwsfs_host_model
`default_nettype wire

/* File: verification/pwsfs_props.sv */
// checker of the fault sequencer outputs
`default_nettype none
module pwsfs_props #(
  parameter int ALERT_CYC = 100
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset
  input wire pwsfs_pkg::pwsfs_sense_s sense_in, // comparators
  input wire pwsfs_pkg::pwsfs_drive_s drive_out, // switch drive
  input wire logic alert_o, // alert level
  input wire logic pack_disconnect_n_oe, // pull low
  input wire logic sensor_bias_rail // bias rail
);
  import pwsfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // cutoff window is the 400..600 spread around 500
  localparam int CUT_LO = ALERT_CYC * 4 / 5;
  localparam int CUT_HI = ALERT_CYC * 6 / 5;
  logic ov_sel;
  logic sw;
  int alert_cnt;
  assign ov_sel = sense_in.ov_pin_grounded ? sense_in.ov_int : sense_in.ov_ext;
  assign sw = drive_out.sw_enable;
  always_ff @(posedge aclk) begin
    if (!aresetn || !alert_o) begin
      alert_cnt <= 0;
    end else begin
      alert_cnt <= alert_cnt + 1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ov_fast_open: assert property ($rose(ov_sel) && sw |-> ##[1:19] !sw)
    else $error("switch stayed closed on overvoltage");
  a_ov_no_disch: assert property (ov_sel && $past(ov_sel, 4) |-> !drive_out.discharge_en)
    else $error("discharge on during overvoltage");
  a_die_open: assert property ($rose(sense_in.die_hot) && sw |-> ##[1:6] !sw)
    else $error("switch stayed closed on die overheat");
  a_die_no_disch: assert property (sense_in.die_hot && $past(sense_in.die_hot, 4)
    |-> !drive_out.discharge_en)
    else $error("discharge on during die overheat");
  a_short_open: assert property ($rose(sense_in.out_low) && sw |-> ##[1:999] !sw)
    else $error("switch stayed closed on output short");
  a_adapter_bias: assert property (!sense_in.on_battery && !$past(sense_in.on_battery, 4)
    |-> sensor_bias_rail)
    else $error("bias rail cycled on adapter");
  a_cutoff_delay: assert property ($rose(pack_disconnect_n_oe)
    |-> alert_o && alert_cnt >= CUT_LO && alert_cnt <= CUT_HI)
    else $error("cutoff outside alert delay window");
  a_cutoff_opens: assert property ($rose(pack_disconnect_n_oe) |-> ##[0:2] !sw)
    else $error("switch closed at cutoff");
  a_release_fast: assert property ($fell(alert_o) |-> ##[0:2] !pack_disconnect_n_oe)
    else $error("disconnect held after release");
  c_cutoff: cover property ($rose(pack_disconnect_n_oe));
  c_soft: cover property ($rose(drive_out.soft_start));
  c_ov: cover property ($rose(ov_sel) && sw);
endmodule : pwsfs_props
bind pwsfs_top pwsfs_props #(.ALERT_CYC(ALERT_CYC)) u_pwsfs_props (.aclk(aclk),
  .aresetn(aresetn), .sense_in(sense_in), .drive_out(drive_out), .alert_o(alert_o),
  .pack_disconnect_n_oe(pack_disconnect_n_oe), .sensor_bias_rail(sensor_bias_rail));
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench of the power switch fault sequencer
`include "pwsfs_params.svh"
`default_nettype none
module tb_top;
  import pwsfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ALC = 100;
  localparam int TON = 50;
  localparam int RDB = 50;
  localparam int REC = 60;
  localparam int PER = 100;
  localparam int BON = 20;
  localparam int STL = 8;
  logic aclk, aresetn, al, al_oe, dc_o, dc_oe, rail, irq, al_w, dc_w;
  pwsfs_sense_s s;
  pwsfs_drive_s d;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  int err_count, samples_checked;
  pwsfs_top #(.ALERT_CYC(ALC), .TURN_ON_CYC(TON), .REL_DEB_CYC(RDB), .DIE_REC_CYC(REC),
    .OV_REC_CYC(REC), .RETRY_CYC(REC), .PERIOD_CYC(PER), .BIAS_ON_CYC(BON),
    .SETTLE_CYC(STL)) u_pwsfs_top (.aclk(aclk), .aresetn(aresetn), .sense_in(s),
    .drive_out(d), .alert_o(al), .alert_oe(al_oe), .pack_disconnect_n_o(dc_o),
    .pack_disconnect_n_oe(dc_oe), .sensor_bias_rail(rail), .irq(irq),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr));
  pwsfs_host_model u_pwsfs_host_model (.alert_o(al), .alert_oe(al_oe), .disc_o(dc_o),
    .disc_oe(dc_oe), .alert_w(al_w), .disc_w(dc_w));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    r = bresp;
    br <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    v = rdat;
    r = rresp;
    rr <= 1'b0;
  endtask : axr
  task automatic rchk(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] r;
    axr(a, v, r);
    chk(v, ev);
    chk(r, er);
  endtask : rchk
  task automatic end_of_test;
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // k: 0 internal overvoltage, 1 external overvoltage, 2 die overheat
  task automatic t_trip(input int k);
    s.ov_pin_grounded <= (k == 0);
    cyc(2);
    s.ov_ext <= (k == 0);
    s.ov_int <= (k == 1);
    cyc(10);
    chk(d.sw_enable, 1);
    s.ov_int <= (k != 2);
    s.ov_ext <= (k != 2);
    s.die_hot <= (k == 2);
    cyc(20);
    chk(d.sw_enable, 0);
    chk(d.discharge_en, 0);
    s.ov_int <= 1'b0;
    s.ov_ext <= 1'b0;
    s.die_hot <= 1'b0;
    cyc(REC - 10);
    chk(d.sw_enable, 0);
    cyc(30);
    chk(d.sw_enable, 1);
  endtask : t_trip
  task automatic t_short;
    int n;
    s.out_low <= 1'b1;
    cyc(20);
    chk(d.sw_enable, 0);
    for (n = 0; n < REC + 40 && !d.soft_start; n++) cyc(1);
    chk(n > REC - 30 && n < REC + 30, 1);
    s.out_low <= 1'b0;
    for (n = 0; n < 2 * REC && !d.sw_enable; n++) cyc(1);
    chk(d.sw_enable, 1);
  endtask : t_short
  task automatic t_ot(input logic b);
    s.over_temp_a <= !b;
    s.over_temp_b <= b;
    cyc(10);
    chk(al_w, 1);
    cyc(ALC * 4 / 5 - 20);
    chk(dc_w, 1);
    chk(d.sw_enable, 1);
    cyc(ALC * 2 / 5 + 10);
    chk(dc_w, 0);
    chk(d.sw_enable, 0);
    s.over_temp_a <= 1'b0;
    s.over_temp_b <= 1'b0;
    cyc(RDB - 10);
    chk(al_w, 1);
    cyc(30);
    chk(al_w, 0);
    chk(dc_w, 1);
    chk(d.sw_enable, 1);
  endtask : t_ot
  task automatic t_irq;
    logic [31:0] v;
    logic [1:0] r;
    rchk(`PWSFS_ADDR_CTRL, `PWSFS_CTRL_RESET, 2'h0);
    rchk(`PWSFS_ADDR_IRQ_MASK, `PWSFS_MASK_RESET, 2'h0);
    rchk(`PWSFS_ADDR_ID, `PWSFS_ID_VALUE, 2'h0);
    rchk(`PWSFS_ADDR_STATUS, 32'h0000_0023, 2'h0);
    rchk(8'h40, 32'h0, 2'h2);
    axw(8'h40, 32'h1, r);
    chk(r, 2'h2);
    axr(`PWSFS_ADDR_IRQ_STAT, v, r);
    axw(`PWSFS_ADDR_IRQ_MASK, 32'h8, r);
    rchk(`PWSFS_ADDR_IRQ_MASK, 32'h8, 2'h0);
    chk(irq, 0);
    t_trip(1);
    chk(irq, 1);
    rchk(`PWSFS_ADDR_IRQ_STAT, 32'h8, 2'h0);
    cyc(3);
    chk(irq, 0);
    axw(`PWSFS_ADDR_IRQ_MASK, 32'h0, r);
    t_trip(2);
    chk(irq, 0);
    axr(`PWSFS_ADDR_IRQ_STAT, v, r);
    chk(v[`PWSFS_EV_DIE], 1);
  endtask : t_irq
  task automatic t_batt;
    int h, l;
    s.adapter_valid <= 1'b0;
    s.on_battery <= 1'b1;
    for (h = 0; h < 3 * PER && rail; h++) cyc(1);
    for (h = 0; h < 3 * PER && !rail; h++) cyc(1);
    for (h = 0; h < 3 * PER && rail; h++) cyc(1);
    for (l = 0; l < 3 * PER && !rail; l++) cyc(1);
    chk(h, BON);
    chk(h + l, PER);
    s.over_temp_a <= 1'b1;
    cyc(STL / 2 - 1);
    s.over_temp_a <= 1'b0;
    cyc(PER);
    chk(al, 0);
    s.over_temp_a <= 1'b1;
    cyc(PER + 10);
    chk(al, 1);
    s.over_temp_a <= 1'b0;
    s.on_battery <= 1'b0;
    s.adapter_valid <= 1'b1;
    cyc(10);
    chk(rail, 1);
    cyc(TON + RDB + 30);
    chk(rail, 1);
    chk(al, 0);
    chk(d.sw_enable, 1);
  endtask : t_batt
  initial begin
    s = '0;
    aresetn = 1'b0;
    {awa, ara, wd, awv, wv, br, arv, rr} = '0;
    ws = 4'hF;
    err_count = 0;
    samples_checked = 0;
    cyc(10);
    chk(d, 0);
    chk(rail, 1);
    aresetn <= 1'b1;
    s.adapter_valid <= 1'b1;
    cyc(TON - 10);
    chk(d.sw_enable, 0);
    cyc(30);
    chk(d.sw_enable, 1);
    t_trip(0);
    t_short;
    t_ot(1'b0);
    t_ot(1'b1);
    t_irq;
    t_batt;
    end_of_test();
  end
  initial begin
    cyc(20000);
    err_count++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
